// ===== common/acltab_pkg.sv
// constants and types for the rule table indirect access block
package acltab_pkg;
	localparam int NUM_PORTS = 4;
	localparam int ENTRY_BYTES = 14;
	localparam int NUM_ENTRIES = 16;
	// host side byte addresses
	localparam logic [7:0] ADDR_IND_CTRL = 8'h6E;
	localparam logic [7:0] ADDR_IND_OFS = 8'h6F;
	localparam logic [7:0] ADDR_IND_DATA = 8'hA0;
	// indirect control fields
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 5;
	localparam int PORT_MSB = 3;
	localparam logic [2:0] SEL_RULE_TABLE = 3'h2;
	localparam logic [3:0] PORT_CODE [NUM_PORTS] = '{4'h1, 4'h2, 4'h3, 4'h5};
	// per-port offsets
	localparam logic [7:0] OFS_BUF_LAST = 8'h0D;
	localparam logic [7:0] OFS_MASK_UPPER = 8'h10;
	localparam logic [7:0] OFS_MASK_LOWER = 8'h11;
	localparam logic [7:0] OFS_ACC_CTRL = 8'h12;
	localparam logic [7:0] OFS_RING_CTRL = 8'h13;
	// access control fields
	localparam int ACC_WSTAT_BIT = 6;
	localparam int ACC_RSTAT_BIT = 5;
	localparam int ACC_TYPE_BIT = 4;
	localparam int ACC_ENTRY_MSB = 3;
	localparam int MASK_UPPER_MSB = 5;
	localparam int RING_BIT = 0;
	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [13:0] MASK_RESET = 14'h0000;
	localparam logic [3:0] ENTRY_RESET = 4'h0;
	localparam logic TYPE_RESET = 1'b0;
	localparam logic STAT_RESET = 1'b1;
	localparam logic RING_RESET = 1'b0;
	// table transfer time
	localparam int CLK_PERIOD_NS = 10;
	localparam int XFER_TIME_NS = 40;
	localparam int XFER_CYCLES = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] XFER_LAST = 3'(XFER_CYCLES - 1);
	typedef logic [7:0] acltab_byte_type;
	typedef acltab_byte_type [ENTRY_BYTES-1:0] acltab_entry_type;
	typedef enum logic {
		ACLTAB_IDLE = 1'b0,
		ACLTAB_BUSY = 1'b1
	} acltab_xfer_state_type;
endpackage

// ===== common/acltab_xfer_if.sv
// transfer channel between port control and its table store
`timescale 1ns/1ns
`default_nettype none
interface acltab_xfer_if;
	import acltab_pkg::*;
	logic req;
	logic is_write;
	logic [3:0] entry;
	logic [ENTRY_BYTES-1:0] mask;
	acltab_entry_type wbuf;
	logic done;
	acltab_entry_type rbuf;
	modport ctrl (output req, is_write, entry, mask, wbuf, input done, rbuf);
	modport store (input req, is_write, entry, mask, wbuf, output done, rbuf);
endinterface
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the rule table indirect access block
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
	import acltab_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [NUM_PORTS-1:0] ring_single_entry_miss;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;

	acltab_indirect u_dut (
		.mclk(mclk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.ring_single_entry_miss(ring_single_entry_miss)
	);

	always #5 mclk = ~mclk;

	task automatic finish_test;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// cut a hang short well past the expected run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 10000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] got);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		`CHECK(reg_rvalid, 1'b1)
		got = reg_rdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		`CHECK(v, exp)
	endtask

	task automatic sel(input int p);
		bus_wr(ADDR_IND_CTRL, {SEL_RULE_TABLE, 1'b0, PORT_CODE[p]});
	endtask

	task automatic ind_wr(input int p, input logic [7:0] ofs, input logic [7:0] d);
		sel(p);
		bus_wr(ADDR_IND_OFS, ofs);
		bus_wr(ADDR_IND_DATA, d);
	endtask

	task automatic ind_rd(input int p, input logic [7:0] ofs, input logic [7:0] exp);
		sel(p);
		bus_wr(ADDR_IND_OFS, ofs);
		rd_chk(ADDR_IND_DATA, exp);
	endtask

	// poll the access control byte until the given status bit returns high
	task automatic wait_stat(input int b);
		logic [7:0] v;
		int n;
		rd(ADDR_IND_DATA, v);
		`CHECK(v[b], 1'b0)
		n = 0;
		while (v[b] !== 1'b1 && n < 12) begin
			rd(ADDR_IND_DATA, v);
			n++;
		end
		`CHECK(v[b], 1'b1)
	endtask

	task automatic test_reset;
		for (int p = 0; p < NUM_PORTS; p++) begin
			ind_rd(p, OFS_MASK_UPPER, 8'h00);
			ind_rd(p, OFS_MASK_LOWER, 8'h00);
			ind_rd(p, OFS_ACC_CTRL, 8'h60);
			ind_rd(p, OFS_RING_CTRL, 8'h00);
		end
		`CHECK(ring_single_entry_miss, 4'h0)
		$display("test_reset done");
	endtask

	task automatic test_masks;
		ind_wr(1, OFS_MASK_UPPER, 8'hFF);
		ind_rd(1, OFS_MASK_UPPER, 8'h3F);
		ind_wr(1, OFS_MASK_LOWER, 8'hA5);
		ind_rd(1, OFS_MASK_LOWER, 8'hA5);
		ind_wr(1, OFS_MASK_UPPER, 8'h00);
		ind_wr(1, OFS_MASK_LOWER, 8'h00);
		$display("test_masks done");
	endtask

	task automatic test_ring;
		ind_wr(2, OFS_RING_CTRL, 8'hFF);
		ind_rd(2, OFS_RING_CTRL, 8'h01);
		`CHECK(ring_single_entry_miss, 4'b0100)
		ind_wr(2, OFS_RING_CTRL, 8'h00);
		ind_rd(2, OFS_RING_CTRL, 8'h00);
		`CHECK(ring_single_entry_miss, 4'b0000)
		$display("test_ring done");
	endtask

	task automatic test_read_req;
		// reserved bit set in the request must not stick
		ind_wr(1, OFS_ACC_CTRL, 8'h85);
		wait_stat(ACC_RSTAT_BIT);
		rd_chk(ADDR_IND_DATA, 8'h65);
		$display("test_read_req done");
	endtask

	task automatic test_write_commit;
		for (int i = 0; i < ENTRY_BYTES; i++) begin
			ind_wr(3, 8'(i), 8'h30 + 8'(i));
		end
		// mask bits 13 and 1 only: entry bytes 0x00 and 0x0C
		ind_wr(3, OFS_MASK_UPPER, 8'h20);
		ind_wr(3, OFS_MASK_LOWER, 8'h02);
		ind_wr(3, OFS_ACC_CTRL, 8'h1F);
		// request while busy is dropped
		bus_wr(ADDR_IND_DATA, 8'h03);
		wait_stat(ACC_WSTAT_BIT);
		rd_chk(ADDR_IND_DATA, 8'h7F);
		for (int i = 0; i < ENTRY_BYTES; i++) begin
			ind_wr(3, 8'(i), 8'h00);
		end
		ind_wr(3, OFS_MASK_UPPER, 8'h3F);
		ind_wr(3, OFS_MASK_LOWER, 8'hFF);
		ind_wr(3, OFS_ACC_CTRL, 8'h0F);
		wait_stat(ACC_RSTAT_BIT);
		for (int i = 0; i < ENTRY_BYTES; i++) begin
			ind_rd(3, 8'(i), (i == 0) ? 8'h30 : (i == 12) ? 8'h3C : 8'h00);
		end
		$display("test_write_commit done");
	endtask

	task automatic test_isolation;
		ind_wr(0, OFS_MASK_UPPER, 8'h3F);
		ind_wr(0, OFS_MASK_LOWER, 8'hFF);
		ind_wr(0, OFS_ACC_CTRL, 8'h0F);
		wait_stat(ACC_RSTAT_BIT);
		for (int i = 0; i < ENTRY_BYTES; i++) begin
			ind_rd(0, 8'(i), 8'h00);
		end
		ind_rd(3, 8'h00, 8'h30);
		ind_rd(3, OFS_ACC_CTRL, 8'h6F);
		$display("test_isolation done");
	endtask

	// port 0: ring mode, a write and reads with partial masks
	task automatic test_port0;
		ind_wr(0, OFS_RING_CTRL, 8'h01);
		`CHECK(ring_single_entry_miss, 4'b0001)
		ind_wr(0, OFS_RING_CTRL, 8'h00);
		ind_wr(0, 8'h0D, 8'hA7);
		ind_wr(0, 8'h00, 8'h5A);
		ind_wr(0, OFS_MASK_UPPER, 8'h00);
		ind_wr(0, OFS_MASK_LOWER, 8'h01);
		ind_wr(0, OFS_ACC_CTRL, 8'h12);
		wait_stat(ACC_WSTAT_BIT);
		ind_wr(0, 8'h0D, 8'h11);
		ind_wr(0, OFS_MASK_UPPER, 8'h20);
		ind_wr(0, OFS_MASK_LOWER, 8'h00);
		ind_wr(0, OFS_ACC_CTRL, 8'h02);
		wait_stat(ACC_RSTAT_BIT);
		ind_rd(0, 8'h0D, 8'h11);
		ind_rd(0, 8'h00, 8'h00);
		ind_wr(0, OFS_MASK_UPPER, 8'h00);
		ind_wr(0, OFS_MASK_LOWER, 8'h01);
		ind_wr(0, OFS_ACC_CTRL, 8'h02);
		wait_stat(ACC_RSTAT_BIT);
		ind_rd(0, 8'h0D, 8'hA7);
		$display("test_port0 done");
	endtask

	task automatic test_refuse;
		ind_rd(3, 8'h00, 8'h30);
		// same port code, another table selected
		bus_wr(ADDR_IND_CTRL, 8'h25);
		rd_chk(ADDR_IND_DATA, 8'h00);
		bus_wr(ADDR_IND_DATA, 8'hFF);
		ind_rd(3, 8'h00, 8'h30);
		rd_chk(8'h55, 8'h00);
		ind_rd(0, 8'h0E, 8'h00);
		$display("test_refuse done");
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		test_reset();
		test_masks();
		test_ring();
		test_read_req();
		test_write_commit();
		test_isolation();
		test_port0();
		test_refuse();
		finish_test();
	end
endmodule
`default_nettype wire

// ===== verilog/acltab_indirect.sv
// indirect host access to per-port rule table holding buffers and control
`timescale 1ns/1ns
`default_nettype none
module acltab_indirect
	import acltab_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// host register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// filter configuration per port
	output logic [NUM_PORTS-1:0] ring_single_entry_miss
);
	typedef struct packed {
		acltab_entry_type buffer;
		logic [ENTRY_BYTES-1:0] mask;
		logic acc_type;
		logic [3:0] acc_entry;
		logic wstat;
		logic rstat;
		logic ring;
		logic req;
	} acltab_port_type;

	typedef struct packed {
		logic [7:0] ind_ctrl;
		logic [7:0] ind_ofs;
		logic [7:0] rdata;
		logic rvalid;
		acltab_port_type [NUM_PORTS-1:0] port;
	} acltab_top_state_type;

	localparam acltab_port_type PORT_RESET = '{
		buffer: '0,
		mask: MASK_RESET,
		acc_type: TYPE_RESET,
		acc_entry: ENTRY_RESET,
		wstat: STAT_RESET,
		rstat: STAT_RESET,
		ring: RING_RESET,
		req: 1'b0
	};

	acltab_top_state_type st;
	acltab_top_state_type next_st;

	logic tab_sel;
	logic data_wr;
	logic data_rd;
	logic [NUM_PORTS-1:0] port_hit;
	logic [NUM_PORTS-1:0] done_v;
	acltab_entry_type rbuf_v [NUM_PORTS];
	logic [7:0] sel_byte;

	assign tab_sel = st.ind_ctrl[SEL_MSB:SEL_LSB] == SEL_RULE_TABLE;
	assign data_wr = reg_wr && reg_addr == ADDR_IND_DATA && tab_sel;
	assign data_rd = reg_rd && reg_addr == ADDR_IND_DATA && tab_sel;

	// byte that the data register shows for one port
	function automatic logic [7:0] port_byte(acltab_port_type pt, logic [7:0] ofs);
		logic [7:0] v;
		v = 8'h00;
		if (ofs <= OFS_BUF_LAST) begin
			v = pt.buffer[ofs[3:0]];
		end else if (ofs == OFS_MASK_UPPER) begin
			v = {2'b00, pt.mask[ENTRY_BYTES-1:8]};
		end else if (ofs == OFS_MASK_LOWER) begin
			v = pt.mask[7:0];
		end else if (ofs == OFS_ACC_CTRL) begin
			v = {1'b0, pt.wstat, pt.rstat, pt.acc_type, pt.acc_entry};
		end else if (ofs == OFS_RING_CTRL) begin
			v = {7'h00, pt.ring};
		end
		return v;
	endfunction

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			acltab_xfer_if xif ();
			acltab_store u_store (
				.mclk(mclk),
				.rst_n(rst_n),
				.xfer(xif.store)
			);
			assign xif.req = st.port[gp].req;
			assign xif.is_write = st.port[gp].acc_type;
			assign xif.entry = st.port[gp].acc_entry;
			assign xif.mask = st.port[gp].mask;
			assign xif.wbuf = st.port[gp].buffer;
			assign done_v[gp] = xif.done;
			assign rbuf_v[gp] = xif.rbuf;
			assign port_hit[gp] = st.ind_ctrl[PORT_MSB:0] == PORT_CODE[gp];
			assign ring_single_entry_miss[gp] = st.port[gp].ring;
		end
	endgenerate

	always_comb begin
		sel_byte = 8'h00;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (port_hit[p]) begin
				sel_byte = port_byte(st.port[p], st.ind_ofs);
			end
		end
	end

	always_comb begin
		next_st = st;
		next_st.rvalid = reg_rd;
		next_st.rdata = 8'h00;
		if (reg_wr && reg_addr == ADDR_IND_CTRL) begin
			next_st.ind_ctrl = reg_wdata;
		end
		if (reg_wr && reg_addr == ADDR_IND_OFS) begin
			next_st.ind_ofs = reg_wdata;
		end
		if (reg_rd && reg_addr == ADDR_IND_CTRL) begin
			next_st.rdata = st.ind_ctrl;
		end else if (reg_rd && reg_addr == ADDR_IND_OFS) begin
			next_st.rdata = st.ind_ofs;
		end else if (data_rd) begin
			next_st.rdata = sel_byte;
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			next_st.port[p].req = 1'b0;
			if (done_v[p]) begin
				if (st.port[p].acc_type) begin
					next_st.port[p].wstat = 1'b1;
				end else begin
					next_st.port[p].rstat = 1'b1;
					for (int b = 0; b < ENTRY_BYTES; b++) begin
						if (st.port[p].mask[ENTRY_BYTES-1-b]) begin
							next_st.port[p].buffer[b] = rbuf_v[p][b];
						end
					end
				end
			end
			if (data_wr && port_hit[p]) begin
				if (st.ind_ofs <= OFS_BUF_LAST) begin
					next_st.port[p].buffer[st.ind_ofs[3:0]] = reg_wdata;
				end else if (st.ind_ofs == OFS_MASK_UPPER) begin
					next_st.port[p].mask[ENTRY_BYTES-1:8] = reg_wdata[MASK_UPPER_MSB:0];
				end else if (st.ind_ofs == OFS_MASK_LOWER) begin
					next_st.port[p].mask[7:0] = reg_wdata;
				end else if (st.ind_ofs == OFS_ACC_CTRL) begin
					// a request while a transfer runs is dropped
					if (st.port[p].wstat && st.port[p].rstat) begin
						next_st.port[p].acc_type = reg_wdata[ACC_TYPE_BIT];
						next_st.port[p].acc_entry = reg_wdata[ACC_ENTRY_MSB:0];
						next_st.port[p].req = 1'b1;
						if (reg_wdata[ACC_TYPE_BIT]) begin
							next_st.port[p].wstat = 1'b0;
						end else begin
							next_st.port[p].rstat = 1'b0;
						end
					end
				end else if (st.ind_ofs == OFS_RING_CTRL) begin
					next_st.port[p].ring = reg_wdata[RING_BIT];
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '{
				ind_ctrl: CTRL_RESET,
				ind_ofs: CTRL_RESET,
				rdata: 8'h00,
				rvalid: 1'b0,
				port: {NUM_PORTS{PORT_RESET}}
			};
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;

	// port 0 helpers for the checks below
	logic ofs_wr0;
	logic ofs_rd0;
	logic acc_ok0;
	assign ofs_wr0 = data_wr && port_hit[0];
	assign ofs_rd0 = data_rd && port_hit[0];
	assign acc_ok0 = ofs_wr0 && st.ind_ofs == OFS_ACC_CTRL
		&& st.port[0].wstat && st.port[0].rstat;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_rst_stat;
		$rose(rst_n) |-> st.port[0].wstat && st.port[0].rstat && !st.port[0].acc_type;
	endproperty
	a_rst_stat: assert property (p_rst_stat) else $error("status not high after reset");

	property p_wr_cycle;
		acc_ok0 && reg_wdata[ACC_TYPE_BIT]
			|=> !st.port[0].wstat [*6] ##1 st.port[0].wstat;
	endproperty
	a_wr_cycle: assert property (p_wr_cycle) else $error("write status sequence wrong");

	property p_rd_cycle;
		acc_ok0 && !reg_wdata[ACC_TYPE_BIT]
			|=> !st.port[0].rstat [*6] ##1 st.port[0].rstat;
	endproperty
	a_rd_cycle: assert property (p_rd_cycle) else $error("read status sequence wrong");

	property p_entry;
		acc_ok0 |=> st.port[0].acc_entry == $past(reg_wdata[ACC_ENTRY_MSB:0])
			&& st.port[0].acc_type == $past(reg_wdata[ACC_TYPE_BIT]);
	endproperty
	a_entry: assert property (p_entry) else $error("entry or type not taken");

	property p_upper;
		ofs_rd0 && st.ind_ofs == OFS_MASK_UPPER
			|=> reg_rdata == {2'b00, $past(st.port[0].mask[13:8])} && reg_rvalid;
	endproperty
	a_upper: assert property (p_upper) else $error("upper mask read wrong");

	property p_lower;
		ofs_wr0 && st.ind_ofs == OFS_MASK_LOWER
			|=> st.port[0].mask[7:0] == $past(reg_wdata);
	endproperty
	a_lower: assert property (p_lower) else $error("lower mask write lost");

	property p_acc_read;
		ofs_rd0 && st.ind_ofs == OFS_ACC_CTRL
			|=> !reg_rdata[7] && reg_rdata[ACC_WSTAT_BIT] == $past(st.port[0].wstat)
			&& reg_rdata[ACC_RSTAT_BIT] == $past(st.port[0].rstat);
	endproperty
	a_acc_read: assert property (p_acc_read) else $error("access control read wrong");

	property p_ring_rd;
		ofs_rd0 && st.ind_ofs == OFS_RING_CTRL
			|=> reg_rdata == {7'h00, $past(st.port[0].ring)};
	endproperty
	a_ring_rd: assert property (p_ring_rd) else $error("ring control read wrong");

	property p_ring_out;
		ofs_wr0 && st.ind_ofs == OFS_RING_CTRL
			|=> ring_single_entry_miss[0] == $past(reg_wdata[0]);
	endproperty
	a_ring_out: assert property (p_ring_out) else $error("ring mode not applied");

	property p_merge_first;
		done_v[0] && !st.port[0].acc_type && st.port[0].mask[13] && !ofs_wr0
			|=> st.port[0].buffer[0] == $past(rbuf_v[0][0]);
	endproperty
	a_merge_first: assert property (p_merge_first) else $error("byte 0 not merged");

	property p_merge_last;
		done_v[0] && !st.port[0].acc_type && !st.port[0].mask[0] && !ofs_wr0
			|=> $stable(st.port[0].buffer[13]);
	endproperty
	a_merge_last: assert property (p_merge_last) else $error("masked byte changed");

	property p_isolate;
		acc_ok0 && !done_v[1] |=> $stable(st.port[1].wstat) && $stable(st.port[1].rstat)
			&& $stable(st.port[1].buffer);
	endproperty
	a_isolate: assert property (p_isolate) else $error("other port disturbed");

	c_read_done: cover property (done_v[0] && !st.port[0].acc_type);
	c_write_done: cover property (done_v[0] && st.port[0].acc_type);
	c_ring_set: cover property (ring_single_entry_miss[0]);
endmodule
`default_nettype wire

// ===== verilog/acltab_store.sv
// one port's sixteen-entry rule table and its transfer engine
`timescale 1ns/1ns
`default_nettype none
module acltab_store
	import acltab_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// transfer channel
	acltab_xfer_if.store xfer
);
	typedef struct packed {
		acltab_xfer_state_type state;
		logic [2:0] count;
		logic is_write;
		logic [3:0] entry;
		logic done;
		acltab_entry_type rbuf;
		acltab_entry_type [NUM_ENTRIES-1:0] mem;
	} acltab_store_state_type;

	acltab_store_state_type st;
	acltab_store_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		unique case (st.state)
			ACLTAB_IDLE: begin
				if (xfer.req) begin
					next_st.state = ACLTAB_BUSY;
					next_st.count = XFER_LAST;
					next_st.is_write = xfer.is_write;
					next_st.entry = xfer.entry;
				end
			end
			ACLTAB_BUSY: begin
				next_st.count = st.count - 3'h1;
				if (st.count == 3'h0) begin
					next_st.state = ACLTAB_IDLE;
					next_st.done = 1'b1;
					for (int b = 0; b < ENTRY_BYTES; b++) begin
						if (xfer.mask[ENTRY_BYTES-1-b]) begin
							if (st.is_write) begin
								next_st.mem[st.entry][b] = xfer.wbuf[b];
							end else begin
								next_st.rbuf[b] = st.mem[st.entry][b];
							end
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign xfer.done = st.done;
	assign xfer.rbuf = st.rbuf;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_xfer_len;
		xfer.req && st.state == ACLTAB_IDLE |-> ##5 st.done;
	endproperty
	a_xfer_len: assert property (p_xfer_len) else $error("transfer length wrong");

	property p_commit;
		st.done && st.is_write && $past(xfer.mask[13])
			|-> st.mem[st.entry][0] == $past(xfer.wbuf[0]);
	endproperty
	a_commit: assert property (p_commit) else $error("enabled byte not committed");
endmodule
`default_nettype wire
